// ===== design/piopc_port_ctrl.sv
// three general-purpose ports behind an AXI4-Lite register slave
`timescale 1ns/10ps
`default_nettype none

module piopc_port_ctrl #(
  parameter logic [piopc_pkg::N_PINS-1:0] OUT_ONLY_MASK = piopc_pkg::NO_OUT_ONLY
) (
  input wire logic aclk, // bus clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [piopc_pkg::ADDR_W-1:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [piopc_pkg::ADDR_W-1:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic [piopc_pkg::N_PINS-1:0] pad_in, // pin levels
  output logic [piopc_pkg::N_PINS-1:0] pad_out, // pin drive values
  output logic [piopc_pkg::N_PINS-1:0] pad_oe, // pin output enables
  output logic [piopc_pkg::N_PINS-1:0] in_buf_en, // input buffer enables
  output logic [piopc_pkg::N_PINS-1:0] pull_up_on, // pull-up devices on
  output logic [piopc_pkg::N_PINS-1:0] slew_limit_on, // slew limiting on
  output logic [piopc_pkg::N_PINS-1:0] high_drive_on, // high drive on
  input wire logic [piopc_pkg::N_PINS-1:0] periph_dig_en, // shared digital enables
  input wire logic [piopc_pkg::N_PINS-1:0] periph_oe, // shared output enables
  input wire logic [piopc_pkg::N_PINS-1:0] periph_out, // shared output values
  input wire logic [piopc_pkg::N_PINS-1:0] periph_ana_en // shared analog enables
);

  localparam int N = piopc_pkg::N_PINS;

  typedef struct packed {
    logic [N-1:0] out_latch;
    logic [N-1:0] pin_direction_bit;
    logic [N-1:0] pull_up_enable_bit;
    logic [N-1:0] slew_limit_enable_bit;
    logic [N-1:0] high_drive_select_bit;
    logic [N-1:0] pin_sync;
    logic [N-1:0] dig_en;
    logic [N-1:0] dig_oe;
    logic [N-1:0] dig_out;
    logic [N-1:0] ana_en;
    logic [N-1:0] pad_out;
    logic [N-1:0] pad_oe;
    logic [N-1:0] ibe;
    logic [N-1:0] pull_on;
    logic [N-1:0] slew_on;
    logic [N-1:0] drive_hi;
    logic aw_got;
    logic w_got;
    logic [piopc_pkg::ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic wlane0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } piopc_state_t;

  piopc_state_t state_ff;
  piopc_state_t nxt_state;

  logic [N-1:0] c_oe;
  logic [N-1:0] c_out;
  logic [N-1:0] c_ibe;
  logic [N-1:0] c_pull;
  logic [N-1:0] c_slew;
  logic [N-1:0] c_drive;
  logic [N-1:0] rd_vec;

  function automatic int port_w(input logic [2:0] p);
    case (p)
      piopc_pkg::PORT_A: port_w = piopc_pkg::PA_W;
      piopc_pkg::PORT_B: port_w = piopc_pkg::PB_W;
      piopc_pkg::PORT_C: port_w = piopc_pkg::PC_W;
      default: port_w = 0;
    endcase
  endfunction

  function automatic int port_lsb(input logic [2:0] p);
    case (p)
      piopc_pkg::PORT_A: port_lsb = piopc_pkg::PA_LSB;
      piopc_pkg::PORT_B: port_lsb = piopc_pkg::PB_LSB;
      piopc_pkg::PORT_C: port_lsb = piopc_pkg::PC_LSB;
      default: port_lsb = 0;
    endcase
  endfunction

  function automatic logic [N-1:0] port_mask(input logic [2:0] p);
    logic [N-1:0] ones;
    ones = '1;
    port_mask = (ones >> (N - port_w(p))) << port_lsb(p);
  endfunction

  function automatic logic [2:0] addr_port(input logic [piopc_pkg::ADDR_W-1:0] a);
    addr_port = a[piopc_pkg::PORT_LSB +: piopc_pkg::IDX_W];
  endfunction

  function automatic logic [2:0] addr_reg(input logic [piopc_pkg::ADDR_W-1:0] a);
    addr_reg = a[piopc_pkg::REG_LSB +: piopc_pkg::IDX_W];
  endfunction

  function automatic logic addr_ok(input logic [piopc_pkg::ADDR_W-1:0] a);
    addr_ok = (port_w(addr_port(a)) != 0) && (addr_reg(a) <= piopc_pkg::REG_DRIVE);
  endfunction

  // replace one port's slice of a pin vector
  function automatic logic [N-1:0] merge(input logic [N-1:0] old, input logic [2:0] p,
                                         input logic [31:0] wd);
    logic [N-1:0] m;
    m = port_mask(p);
    merge = (old & ~m) | (N'(wd << port_lsb(p)) & m);
  endfunction

  function automatic logic [31:0] extract(input logic [N-1:0] v, input logic [2:0] p);
    extract = 32'((v & port_mask(p)) >> port_lsb(p));
  endfunction

  for (genvar i = 0; i < N; i++)
  begin : g_pin
    piopc_pin_cell u_cell (
      .dir(state_ff.pin_direction_bit[i]),
      .latch(state_ff.out_latch[i]),
      .dig_en(state_ff.dig_en[i]),
      .dig_oe(state_ff.dig_oe[i]),
      .dig_out(state_ff.dig_out[i]),
      .ana_en(state_ff.ana_en[i]),
      .pull_bit(state_ff.pull_up_enable_bit[i]),
      .slew_bit(state_ff.slew_limit_enable_bit[i]),
      .drive_bit(state_ff.high_drive_select_bit[i]),
      .out_only(OUT_ONLY_MASK[i]),
      .oe(c_oe[i]),
      .dout(c_out[i]),
      .ibe(c_ibe[i]),
      .pull_on(c_pull[i]),
      .slew_on(c_slew[i]),
      .drive_hi(c_drive[i])
    );
  end

  // outputs read the latch, inputs the synchronised pin or zero when the buffer is off
  assign rd_vec = (state_ff.pin_direction_bit & state_ff.out_latch) |
                  (~state_ff.pin_direction_bit & state_ff.ibe & state_ff.pin_sync);

  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.pin_sync = pad_in;
    nxt_state.dig_en = periph_dig_en;
    nxt_state.dig_oe = periph_oe;
    nxt_state.dig_out = periph_out;
    nxt_state.ana_en = periph_ana_en;
    nxt_state.pad_out = c_out;
    nxt_state.pad_oe = c_oe;
    nxt_state.ibe = c_ibe;
    nxt_state.pull_on = c_pull;
    nxt_state.slew_on = c_slew;
    nxt_state.drive_hi = c_drive;

    if (awvalid && state_ff.awready)
    begin
      nxt_state.aw_got = 1'b1;
      nxt_state.waddr = awaddr;
    end
    if (wvalid && state_ff.wready)
    begin
      nxt_state.w_got = 1'b1;
      nxt_state.wdata = wdata;
      nxt_state.wlane0 = wstrb[0];
    end

    // both halves held: commit the write and raise the response
    if (state_ff.aw_got && state_ff.w_got && !state_ff.bvalid)
    begin
      nxt_state.aw_got = 1'b0;
      nxt_state.w_got = 1'b0;
      nxt_state.bvalid = 1'b1;
      nxt_state.bresp = piopc_pkg::RESP_SLVERR;
      if (addr_ok(state_ff.waddr))
      begin
        nxt_state.bresp = piopc_pkg::RESP_OKAY;
        // every port slice is at most one byte wide, so lane 0 carries it all
        if (state_ff.wlane0)
        begin
          unique case (addr_reg(state_ff.waddr))
            piopc_pkg::REG_DATA:
              nxt_state.out_latch =
                merge(state_ff.out_latch, addr_port(state_ff.waddr), state_ff.wdata);
            piopc_pkg::REG_DIR:
              nxt_state.pin_direction_bit =
                merge(state_ff.pin_direction_bit, addr_port(state_ff.waddr), state_ff.wdata);
            piopc_pkg::REG_PULL:
              nxt_state.pull_up_enable_bit =
                merge(state_ff.pull_up_enable_bit, addr_port(state_ff.waddr), state_ff.wdata);
            piopc_pkg::REG_SLEW:
              nxt_state.slew_limit_enable_bit =
                merge(state_ff.slew_limit_enable_bit, addr_port(state_ff.waddr),
                      state_ff.wdata);
            piopc_pkg::REG_DRIVE:
              nxt_state.high_drive_select_bit =
                merge(state_ff.high_drive_select_bit, addr_port(state_ff.waddr),
                      state_ff.wdata);
            default:
              nxt_state.bresp = piopc_pkg::RESP_SLVERR;
          endcase
        end
      end
    end
    else if (state_ff.bvalid && bready)
    begin
      nxt_state.bvalid = 1'b0;
    end
    nxt_state.awready = !nxt_state.aw_got && !nxt_state.bvalid;
    nxt_state.wready = !nxt_state.w_got && !nxt_state.bvalid;

    if (arvalid && state_ff.arready)
    begin
      nxt_state.rvalid = 1'b1;
      nxt_state.rresp = piopc_pkg::RESP_SLVERR;
      nxt_state.rdata = piopc_pkg::RDATA_NONE;
      if (addr_ok(araddr))
      begin
        nxt_state.rresp = piopc_pkg::RESP_OKAY;
        unique case (addr_reg(araddr))
          piopc_pkg::REG_DATA:
            nxt_state.rdata = extract(rd_vec, addr_port(araddr));
          piopc_pkg::REG_DIR:
            nxt_state.rdata = extract(state_ff.pin_direction_bit, addr_port(araddr));
          piopc_pkg::REG_PULL:
            nxt_state.rdata = extract(state_ff.pull_up_enable_bit, addr_port(araddr));
          piopc_pkg::REG_SLEW:
            nxt_state.rdata = extract(state_ff.slew_limit_enable_bit, addr_port(araddr));
          piopc_pkg::REG_DRIVE:
            nxt_state.rdata = extract(state_ff.high_drive_select_bit, addr_port(araddr));
          default:
            nxt_state.rresp = piopc_pkg::RESP_SLVERR;
        endcase
      end
    end
    else if (state_ff.rvalid && rready)
    begin
      nxt_state.rvalid = 1'b0;
    end
    nxt_state.arready = !nxt_state.rvalid;
  end

  // reset holds peripherals off, all pins input, pin controls cleared
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign awready = state_ff.awready;
  assign wready = state_ff.wready;
  assign bvalid = state_ff.bvalid;
  assign bresp = state_ff.bresp;
  assign arready = state_ff.arready;
  assign rvalid = state_ff.rvalid;
  assign rdata = state_ff.rdata;
  assign rresp = state_ff.rresp;
  assign pad_out = state_ff.pad_out;
  assign pad_oe = state_ff.pad_oe;
  assign in_buf_en = state_ff.ibe;
  assign pull_up_on = state_ff.pull_on;
  assign slew_limit_on = state_ff.slew_on;
  assign high_drive_on = state_ff.drive_hi;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_reset_dir_in: assert property (
    !$past(aresetn) |-> (state_ff.pin_direction_bit == piopc_pkg::PIN_RST) &&
                        (pad_oe == piopc_pkg::PIN_RST))
    else $error("direction or output enable not clear after reset");

  a_reset_pin_ctl: assert property (
    !$past(aresetn) |-> (state_ff.pull_up_enable_bit == piopc_pkg::PIN_RST) &&
                        (state_ff.slew_limit_enable_bit == piopc_pkg::PIN_RST) &&
                        (state_ff.high_drive_select_bit == piopc_pkg::PIN_RST))
    else $error("pin control bits not clear after reset");

  a_gpio_out_en: assert property (
    $past(aresetn) |-> ((pad_oe ^ $past(state_ff.pin_direction_bit)) &
                        ~$past(state_ff.dig_en | state_ff.ana_en)) == '0)
    else $error("port output enable does not follow direction");

  a_periph_owns_oe: assert property (
    $past(aresetn) |-> ((pad_oe ^ $past(state_ff.dig_oe)) &
                        $past(state_ff.dig_en & ~state_ff.ana_en)) == '0)
    else $error("shared function does not own the output buffer");

  a_analog_kills: assert property (
    $past(aresetn) |-> ((pad_oe | in_buf_en) & $past(state_ff.ana_en)) == '0)
    else $error("analog pin still has a buffer on");

  a_in_buf_rule: assert property (
    $past(aresetn) |-> in_buf_en == ~($past(state_ff.ana_en) | OUT_ONLY_MASK))
    else $error("input buffer enable wrong");

  a_pull_off_out: assert property (
    (pull_up_on & (pad_oe | $past(state_ff.ana_en))) == '0)
    else $error("pull-up on while driving");

  a_read_source: assert property (
    (arvalid && arready && araddr == piopc_pkg::ADDR_A_DATA)
      |=> rvalid && rdata == extract($past(rd_vec), piopc_pkg::PORT_A))
    else $error("data read returned the wrong source");

  a_rvalid_hold: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped before rready");

  a_bvalid_hold: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped before bready");

  c_write_done: cover property (bvalid && bready && bresp == piopc_pkg::RESP_OKAY);
  c_read_done: cover property (rvalid && rready && rresp == piopc_pkg::RESP_OKAY);
  c_analog_pin: cover property (state_ff.ana_en != '0 && state_ff.dig_en != '0);
  c_gpio_drive: cover property (pad_oe != '0 && state_ff.dig_en == '0);

endmodule

`default_nettype wire

// ===== common/piopc_pkg.sv
// constants for the three-port general-purpose pin controller
package piopc_pkg;

  // pin count and port split
  localparam int N_PINS = 16;
  localparam int N_PORTS = 3;
  localparam int PA_W = 6;
  localparam int PB_W = 6;
  localparam int PC_W = 4;
  localparam int PA_LSB = 0;
  localparam int PB_LSB = PA_LSB + PA_W;
  localparam int PC_LSB = PB_LSB + PB_W;

  // port and register indices inside a byte address
  localparam int ADDR_W = 8;
  localparam int PORT_LSB = 5;
  localparam int REG_LSB = 2;
  localparam int IDX_W = 3;
  localparam logic [2:0] PORT_A = 3'h0;
  localparam logic [2:0] PORT_B = 3'h1;
  localparam logic [2:0] PORT_C = 3'h2;
  localparam logic [2:0] REG_DATA = 3'h0;
  localparam logic [2:0] REG_DIR = 3'h1;
  localparam logic [2:0] REG_PULL = 3'h2;
  localparam logic [2:0] REG_SLEW = 3'h3;
  localparam logic [2:0] REG_DRIVE = 3'h4;

  // byte address of port A data, used by the read check
  localparam logic [7:0] ADDR_A_DATA = 8'h00;

  // reset values and masks
  localparam logic [15:0] PIN_RST = 16'h0000;
  localparam logic [15:0] NO_OUT_ONLY = 16'h0000;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] RDATA_NONE = 32'h0000_0000;

endpackage

// ===== design/piopc_pin_cell.sv
// per-pin buffer steering: analog over shared digital over port logic
`timescale 1ns/10ps
`default_nettype none

module piopc_pin_cell (
  input wire logic dir, // pin direction bit
  input wire logic latch, // output latch value
  input wire logic dig_en, // shared digital function enabled
  input wire logic dig_oe, // shared function output enable
  input wire logic dig_out, // shared function output value
  input wire logic ana_en, // shared analog function enabled
  input wire logic pull_bit, // pull-up enable bit
  input wire logic slew_bit, // slew limit enable bit
  input wire logic drive_bit, // high drive select bit
  input wire logic out_only, // pin has no input buffer
  output logic oe, // output buffer enable
  output logic dout, // output buffer value
  output logic ibe, // input buffer enable
  output logic pull_on, // pull-up device on
  output logic slew_on, // slew limiting on
  output logic drive_hi // high drive on
);

  // analog wins over the output and input buffer enables, then the shared digital function
  assign oe = ana_en ? 1'b0 : (dig_en ? dig_oe : dir);
  assign dout = dig_en ? dig_out : latch;
  assign ibe = !ana_en && !out_only;
  // a pin that drives, or is analog, never pulls up
  assign pull_on = pull_bit && !oe && !ana_en;
  // slew control means nothing on an input
  assign slew_on = slew_bit && oe;
  assign drive_hi = drive_bit;

endmodule

`default_nettype wire

// ===== sim/piopc_pin_model.sv
// board side of the pads: one weak driver per pin against the port's buffers
`timescale 1ns/10ps
`default_nettype none

module piopc_pin_model (
  input wire logic [piopc_pkg::N_PINS-1:0] pad_out, // port drive values
  input wire logic [piopc_pkg::N_PINS-1:0] pad_oe, // port output enables
  input wire logic [piopc_pkg::N_PINS-1:0] ext_val, // board level per pin
  output logic [piopc_pkg::N_PINS-1:0] pad_in // level seen at the pins
);
  // every pin has a board driver so no input floats; a driving port wins
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_val);
endmodule

`default_nettype wire

// ===== sim/tb_parallel_io_port_pin_control.sv
// random register and pin traffic for the three-port pin controller
`timescale 1ns/10ps
`default_nettype none

module tb_parallel_io_port_pin_control;
  localparam int ORD[5] = '{0, 2, 3, 4, 1};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic [15:0] pad_in, pad_out, pad_oe, in_buf_en, pull_up_on, slew_limit_on, high_drive_on;
  logic [15:0] periph_dig_en = 16'hffff;
  logic [15:0] periph_oe = 16'hffff;
  logic [15:0] periph_out = 16'h0000;
  logic [15:0] periph_ana_en = 16'h0000;
  logic [15:0] ext_val = 16'h0000;
  logic [15:0] cfg [5] = '{default: 16'h0000};
  logic [31:0] seed = 32'h0000_004e;
  int n_fail = 0;
  int samples_checked = 0;

  always #12.5 aclk = ~aclk;

  piopc_port_ctrl u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .in_buf_en(in_buf_en),
    .pull_up_on(pull_up_on), .slew_limit_on(slew_limit_on), .high_drive_on(high_drive_on),
    .periph_dig_en(periph_dig_en), .periph_oe(periph_oe), .periph_out(periph_out),
    .periph_ana_en(periph_ana_en));

  piopc_pin_model u_pins (.pad_out(pad_out), .pad_oe(pad_oe), .ext_val(ext_val),
    .pad_in(pad_in));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic rnd(output logic [31:0] v);
    repeat (32) seed = lfsr_next(seed);
    v = seed;
  endtask

  function automatic logic [7:0] addr_of(input int p, input logic [2:0] r);
    return 8'((p << piopc_pkg::PORT_LSB) | (int'(r) << piopc_pkg::REG_LSB));
  endfunction

  function automatic int plsb(input int p);
    return (p == 0) ? piopc_pkg::PA_LSB : (p == 1) ? piopc_pkg::PB_LSB : piopc_pkg::PC_LSB;
  endfunction

  function automatic logic [15:0] pmask(input int p);
    int w;
    w = (p == 0) ? piopc_pkg::PA_W : (p == 1) ? piopc_pkg::PB_W : piopc_pkg::PC_W;
    return 16'(((1 << w) - 1) << plsb(p));
  endfunction

  // analog wins, then the shared digital function, then the direction bit
  function automatic logic [15:0] exp_oe();
    return ~periph_ana_en & ((periph_dig_en & periph_oe) | (~periph_dig_en & cfg[1]));
  endfunction

  function automatic logic [15:0] exp_dout();
    return (periph_dig_en & periph_out) | (~periph_dig_en & cfg[0]);
  endfunction

  function automatic logic [15:0] exp_rd();
    logic [15:0] oe;
    logic [15:0] pin;
    oe = exp_oe();
    pin = (oe & exp_dout()) | (~oe & ext_val);
    return (cfg[1] & cfg[0]) | (~cfg[1] & ~periph_ana_en & pin);
  endfunction

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    logic da;
    logic dw;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    da = 1'b0;
    dw = 1'b0;
    while (!(da && dw))
    begin
      @(negedge aclk);
      if (awvalid && awready) da = 1'b1;
      if (wvalid && wready) dw = 1'b1;
      @(posedge aclk);
      if (da) awvalid <= 1'b0;
      if (dw) wvalid <= 1'b0;
    end
    @(negedge aclk);
    while (bvalid !== 1'b1) @(negedge aclk);
    // late bready makes the response wait one edge with no taker
    @(posedge aclk);
    bready <= 1'b1;
    @(negedge aclk);
    r = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic da;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    da = 1'b0;
    while (!da)
    begin
      @(negedge aclk);
      da = (arready === 1'b1);
      @(posedge aclk);
      if (da) arvalid <= 1'b0;
    end
    @(negedge aclk);
    while (rvalid !== 1'b1) @(negedge aclk);
    // late rready makes the answer stand one edge with no taker
    @(posedge aclk);
    rready <= 1'b1;
    @(negedge aclk);
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  task automatic chk_regs();
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] e;
    for (int p = 0; p < piopc_pkg::N_PORTS; p++)
      for (int g = 0; g < 5; g++)
      begin
        axi_read(addr_of(p, 3'(g)), d, r);
        e = (g == 0) ? exp_rd() : cfg[g];
        chk("rdata", d, 32'((e & pmask(p)) >> plsb(p)));
        chk("rresp", 32'(r), 32'(piopc_pkg::RESP_OKAY));
      end
  endtask

  // data, pull, slew and drive first, direction last, so no stale latch is driven
  task automatic cfg_port(input int p);
    logic [31:0] v;
    logic [1:0] r;
    logic [15:0] m;
    m = pmask(p);
    for (int k = 0; k < 5; k++)
    begin
      rnd(v);
      axi_write(addr_of(p, 3'(ORD[k])), v, 4'hf, r);
      cfg[ORD[k]] = (cfg[ORD[k]] & ~m) | (16'(v << plsb(p)) & m);
      chk("bresp", 32'(r), 32'(piopc_pkg::RESP_OKAY));
    end
  endtask

  task automatic chk_pins();
    logic [15:0] oe;
    logic [15:0] ib;
    oe = exp_oe();
    // inverted at 16 bits so the upper half of the compare stays zero
    ib = ~periph_ana_en;
    chk("pad_oe", 32'(pad_oe), 32'(oe));
    chk("pad_out", 32'(pad_out & oe), 32'(exp_dout() & oe));
    chk("in_buf_en", 32'(in_buf_en), 32'(ib));
    chk("pull_up_on", 32'(pull_up_on), 32'(cfg[2] & ~oe & ~periph_ana_en));
    chk("slew_limit_on", 32'(slew_limit_on), 32'(cfg[3] & oe));
    chk("high_drive_on", 32'(high_drive_on), 32'(cfg[4]));
  endtask

  initial
  begin
    repeat (60000) @(posedge aclk);
    n_fail++;
    end_sim();
  end

  initial
  begin
    logic [31:0] v;
    logic [31:0] d;
    logic [1:0] r;
    repeat (5) @(posedge aclk);
    // peripheral requests are up during reset, yet nothing may drive
    @(negedge aclk);
    chk("pad_oe", 32'(pad_oe), 32'h0000_0000);
    chk("pin_ctrl", 32'(pull_up_on | slew_limit_on | high_drive_on), 32'h0000_0000);
    @(posedge aclk);
    aresetn <= 1'b1;
    periph_dig_en <= 16'h0000;
    periph_oe <= 16'h0000;
    chk_regs();
    for (int i = 0; i < 30; i++)
    begin
      rnd(v);
      // early passes keep the peripherals off to test plain port logic
      periph_dig_en <= (i < 5) ? 16'h0000 : v[15:0];
      periph_ana_en <= (i < 5) ? 16'h0000 : v[31:16] & v[23:8];
      rnd(v);
      periph_oe <= v[15:0];
      periph_out <= v[31:16];
      rnd(v);
      ext_val <= v[15:0];
      for (int p = 0; p < piopc_pkg::N_PORTS; p++)
        cfg_port(p);
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      chk_pins();
      chk_regs();
    end
    axi_write(addr_of(0, 3'(piopc_pkg::REG_DIR)), 32'hffff_ffff, 4'h0, r);
    chk("bresp", 32'(r), 32'(piopc_pkg::RESP_OKAY));
    for (int k = 0; k < 2; k++)
    begin
      axi_write(k ? addr_of(0, 3'h5) : addr_of(3, 3'h0), 32'hffff_ffff, 4'hf, r);
      chk("bresp", 32'(r), 32'(piopc_pkg::RESP_SLVERR));
      axi_read(k ? addr_of(0, 3'h5) : addr_of(3, 3'h0), d, r);
      chk("rresp", 32'(r), 32'(piopc_pkg::RESP_SLVERR));
      chk("rdata", d, piopc_pkg::RDATA_NONE);
    end
    chk_regs();
    end_sim();
  end
endmodule

`default_nettype wire
